//--- design/banked_sfr_map_slice.v
// banked register map slice: bank 1 upper part, bank 2 lower part, shared core registers
`timescale 1ns/1ps
`include "sfr_map_defines.vh"
module banked_sfr_map_slice #(
  parameter DATA_W = 8
) (
  input  wire              mclk_i,
  input  wire              sys_rst_i,
  input  wire [`ADDR_W-1:0] addr_i,
  input  wire              wr_en_i,
  input  wire [DATA_W-1:0] wr_data_i,
  input  wire              rd_en_i,
  output wire [DATA_W-1:0] rd_data_o,
  output wire              hit_o,
  input  wire              pc_load_i,
  input  wire [DATA_W-1:0] pc_load_low_i,
  input  wire [DATA_W-1:0] indirect_rd_data_i,
  output wire              indirect_wr_o,
  output wire [DATA_W-1:0] indirect_addr_o,
  input  wire [DATA_W-1:0] timer0_count_i,
  output wire              timer0_wr_o,
  input  wire [DATA_W-1:0] port_b_pins_i,
  output wire [DATA_W-1:0] port_b_latch_o,
  input  wire [DATA_W-1:0] conv_result_low_i,
  input  wire [2:0]        alu_flags_i,
  input  wire              alu_flags_we_i,
  input  wire [1:0]        power_flags_i,
  input  wire              power_flags_we_i,
  input  wire [2:0]        int_flags_i,
  input  wire              int_flags_set_i,
  output wire [DATA_W-1:0] serial_control_two_o,
  output wire [DATA_W-1:0] timer2_period_o,
  output wire [DATA_W-1:0] serial_slave_address_o,
  output wire [DATA_W-1:0] serial_port_flags_o,
  output wire [DATA_W-1:0] conv_config_one_o,
  output wire [DATA_W-1:0] cpu_flags_o,
  output wire [DATA_W-1:0] interrupt_control_o,
  output wire [DATA_W-1:0] nvm_data_low_o,
  output wire [DATA_W-1:0] nvm_address_low_o,
  output wire [DATA_W-1:0] nvm_data_high_o,
  output wire [12:0]       pc_o
);

  reg [DATA_W-1:0]            serial_control_two_reg;
  reg [DATA_W-1:0]            timer2_period_reg;
  reg [DATA_W-1:0]            serial_slave_address_reg;
  reg [DATA_W-1:0]            serial_port_flags_reg;
  reg [DATA_W-1:0]            conv_config_one_reg;
  reg [DATA_W-1:0]            pc_low_reg;
  reg [`PC_UPPER_W-1:0]       pc_high_reg;
  reg [`PC_UPPER_W-1:0]       pc_upper_latch_reg;
  reg [DATA_W-1:0]            cpu_flags_reg;
  reg [DATA_W-1:0]            indirect_pointer_reg;
  reg [DATA_W-1:0]            port_b_latch_reg;
  reg [DATA_W-1:0]            interrupt_control_reg;
  reg [DATA_W-1:0]            nvm_data_low_reg;
  reg [DATA_W-1:0]            nvm_address_low_reg;
  reg [DATA_W-1:0]            nvm_data_high_reg;
  reg [DATA_W-1:0]            rd_data_reg;
  reg [DATA_W-1:0]            rd_data_next;
  reg                         hit_next;
  reg                         sel_scr2, sel_per, sel_sadd, sel_sflg, sel_crl, sel_cc1;
  reg                         sel_ind, sel_t0, sel_pclow, sel_stat, sel_ptr, sel_pb;
  reg                         sel_pcu, sel_intc, sel_ndl, sel_nal, sel_ndh;
  wire [6:0]                  low_off;
  wire                        wr_ind, wr_pclow, wr_stat, wr_ptr, wr_pcu, wr_intc;

  assign low_off = addr_i[6:0];

  // address decode; shared core registers match low offset in any bank
  always @* begin
    sel_ind  = (low_off == `LOW_INDIRECT_PORT);
    sel_pclow = (low_off == `LOW_PC_LOW_BYTE);
    sel_stat = (low_off == `LOW_CPU_FLAGS);
    sel_ptr  = (low_off == `LOW_INDIRECT_POINTER);
    sel_pcu  = (low_off == `LOW_PC_UPPER_LATCH);
    sel_intc = (low_off == `LOW_INTERRUPT_CONTROL);
    sel_scr2 = 1'b0;
    sel_per  = 1'b0;
    sel_sadd = 1'b0;
    sel_sflg = 1'b0;
    sel_crl  = 1'b0;
    sel_cc1  = 1'b0;
    sel_t0   = 1'b0;
    sel_pb   = 1'b0;
    sel_ndl  = 1'b0;
    sel_nal  = 1'b0;
    sel_ndh  = 1'b0;
    if (addr_i == `OFF_SERIAL_CONTROL_TWO) begin
      sel_scr2 = 1'b1;
    end else if (addr_i == `OFF_TIMER2_PERIOD) begin
      sel_per = 1'b1;
    end else if (addr_i == `OFF_SERIAL_SLAVE_ADDR) begin
      sel_sadd = 1'b1;
    end else if (addr_i == `OFF_SERIAL_PORT_FLAGS) begin
      sel_sflg = 1'b1;
    end else if (addr_i == `OFF_CONV_RESULT_LOW) begin
      sel_crl = 1'b1;
    end else if (addr_i == `OFF_CONV_CONFIG_ONE) begin
      sel_cc1 = 1'b1;
    end else if (addr_i == `OFF_TIMER0_COUNT) begin
      sel_t0 = 1'b1;
    end else if (addr_i == `OFF_PORT_B_DATA) begin
      sel_pb = 1'b1;
    end else if (addr_i == `OFF_NVM_DATA_LOW) begin
      sel_ndl = 1'b1;
    end else if (addr_i == `OFF_NVM_ADDRESS_LOW) begin
      sel_nal = 1'b1;
    end else if (addr_i == `OFF_NVM_DATA_HIGH) begin
      sel_ndh = 1'b1;
    end
  end

  assign wr_ind  = wr_en_i & sel_ind;
  assign wr_pclow = wr_en_i & sel_pclow;
  assign wr_stat = wr_en_i & sel_stat;
  assign wr_ptr  = wr_en_i & sel_ptr;
  assign wr_pcu  = wr_en_i & sel_pcu;
  assign wr_intc = wr_en_i & sel_intc;

  // read mux; unmapped locations give zero
  always @* begin
    rd_data_next = {DATA_W{1'b0}};
    hit_next     = 1'b1;
    if (sel_ind) begin
      rd_data_next = indirect_rd_data_i;
    end else if (sel_pclow) begin
      rd_data_next = pc_low_reg;
    end else if (sel_stat) begin
      rd_data_next = cpu_flags_reg;
    end else if (sel_ptr) begin
      rd_data_next = indirect_pointer_reg;
    end else if (sel_pcu) begin
      rd_data_next = {3'h0, pc_upper_latch_reg};
    end else if (sel_intc) begin
      rd_data_next = interrupt_control_reg;
    end else if (sel_scr2) begin
      rd_data_next = serial_control_two_reg;
    end else if (sel_per) begin
      rd_data_next = timer2_period_reg;
    end else if (sel_sadd) begin
      rd_data_next = serial_slave_address_reg;
    end else if (sel_sflg) begin
      rd_data_next = serial_port_flags_reg;
    end else if (sel_crl) begin
      rd_data_next = conv_result_low_i;
    end else if (sel_cc1) begin
      rd_data_next = conv_config_one_reg;
    end else if (sel_t0) begin
      rd_data_next = timer0_count_i;
    end else if (sel_pb) begin
      rd_data_next = port_b_pins_i;
    end else if (sel_ndl) begin
      rd_data_next = nvm_data_low_reg;
    end else if (sel_nal) begin
      rd_data_next = nvm_address_low_reg;
    end else if (sel_ndh) begin
      rd_data_next = nvm_data_high_reg;
    end else begin
      rd_data_next = {DATA_W{1'b0}};
      hit_next     = 1'b0;
    end
    if (!rd_en_i) begin
      rd_data_next = {DATA_W{1'b0}};
    end
  end

  // registered read data, one cycle after the read strobe
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      rd_data_reg <= {DATA_W{1'b0}};
    end else begin
      rd_data_reg <= rd_data_next;
    end
  end

  // register writes; unmatched addresses write nothing
  always @(posedge mclk_i) begin
    if (sys_rst_i) begin
      serial_control_two_reg   <= `RST_SERIAL_CONTROL_TWO;
      timer2_period_reg        <= `RST_TIMER2_PERIOD;
      serial_slave_address_reg <= `RST_SERIAL_SLAVE_ADDR;
      serial_port_flags_reg    <= `RST_SERIAL_PORT_FLAGS;
      conv_config_one_reg      <= `RST_CONV_CONFIG_ONE;
      pc_low_reg               <= `RST_PC_LOW_BYTE;
      pc_high_reg              <= `RST_PC_UPPER_LATCH;
      pc_upper_latch_reg       <= `RST_PC_UPPER_LATCH;
      cpu_flags_reg            <= {`RST_CPU_FLAGS_UPPER, 3'h0};
      interrupt_control_reg    <= {`RST_INTERRUPT_UPPER, 1'b0};
    end else begin
      if (wr_en_i && sel_scr2) serial_control_two_reg <= wr_data_i;
      if (wr_en_i && sel_per) timer2_period_reg <= wr_data_i;
      if (wr_en_i && sel_sadd) serial_slave_address_reg <= wr_data_i;
      // only the two mode bits of the serial flags are software-writable
      if (wr_en_i && sel_sflg) begin
        serial_port_flags_reg <= (serial_port_flags_reg & ~`SERIAL_FLAGS_WR_MASK) | (wr_data_i & `SERIAL_FLAGS_WR_MASK);
      end
      if (wr_en_i && sel_cc1) conv_config_one_reg <= wr_data_i & `CONV_CONFIG_MASK;
      if (wr_en_i && sel_pcu) pc_upper_latch_reg <= wr_data_i[`PC_UPPER_W-1:0];
      if (pc_load_i) begin
        pc_high_reg <= pc_upper_latch_reg;
        pc_low_reg  <= pc_load_low_i;
      end else if (wr_pclow) begin
        pc_high_reg <= pc_upper_latch_reg;
        pc_low_reg  <= wr_data_i;
      end
      // status: power flags read-only, alu flags from core win over writes
      if (wr_stat) begin
        cpu_flags_reg <= (cpu_flags_reg & ~`CPU_FLAGS_WR_MASK) | (wr_data_i & `CPU_FLAGS_WR_MASK);
      end
      if (power_flags_we_i) cpu_flags_reg[4:3] <= power_flags_i;
      if (alu_flags_we_i) cpu_flags_reg[2:0] <= alu_flags_i;
      // interrupt flags: hardware set wins over a software clear
      if (wr_intc) interrupt_control_reg <= wr_data_i;
      if (int_flags_set_i) interrupt_control_reg[2:0] <= (wr_intc ? wr_data_i[2:0] : interrupt_control_reg[2:0])
                                                         | int_flags_i;
    end
  end

  // unknown-at-reset registers, loaded only by writes
  always @(posedge mclk_i) begin
    if (wr_ptr) indirect_pointer_reg <= wr_data_i;
    if (wr_en_i && sel_pb) port_b_latch_reg <= wr_data_i;
    if (wr_en_i && sel_ndl) nvm_data_low_reg <= wr_data_i;
    if (wr_en_i && sel_nal) nvm_address_low_reg <= wr_data_i;
    if (wr_en_i && sel_ndh) nvm_data_high_reg <= wr_data_i & `NVM_DATA_HIGH_MASK;
  end

  // counter upper five bits only via pc_o
  assign pc_o                   = {pc_high_reg, pc_low_reg};
  assign rd_data_o              = rd_data_reg;
  assign hit_o                  = hit_next;
  assign indirect_wr_o          = wr_ind;
  assign indirect_addr_o        = indirect_pointer_reg;
  assign timer0_wr_o            = wr_en_i & sel_t0;
  assign port_b_latch_o         = port_b_latch_reg;
  assign serial_control_two_o   = serial_control_two_reg;
  assign timer2_period_o        = timer2_period_reg;
  assign serial_slave_address_o = serial_slave_address_reg;
  assign serial_port_flags_o    = serial_port_flags_reg;
  assign conv_config_one_o      = conv_config_one_reg;
  assign cpu_flags_o            = cpu_flags_reg;
  assign interrupt_control_o    = interrupt_control_reg;
  assign nvm_data_low_o         = nvm_data_low_reg;
  assign nvm_address_low_o      = nvm_address_low_reg;
  assign nvm_data_high_o        = nvm_data_high_reg;

endmodule // banked_sfr_map_slice

//--- inc/sfr_map_defines.vh
// register offsets, field widths and reset values for the banked register map slice
`ifndef SFR_MAP_DEFINES_VH
`define SFR_MAP_DEFINES_VH

`define ADDR_W                  9
// bank 1 upper part
`define OFF_SERIAL_CONTROL_TWO  9'h091
`define OFF_TIMER2_PERIOD       9'h092
`define OFF_SERIAL_SLAVE_ADDR   9'h093
`define OFF_SERIAL_PORT_FLAGS   9'h094
`define OFF_CONV_RESULT_LOW     9'h09e
`define OFF_CONV_CONFIG_ONE     9'h09f
// bank 2 lower part
`define OFF_INDIRECT_PORT       9'h100
`define OFF_TIMER0_COUNT        9'h101
`define OFF_PC_LOW_BYTE         9'h102
`define OFF_CPU_FLAGS           9'h103
`define OFF_INDIRECT_POINTER    9'h104
`define OFF_PORT_B_DATA         9'h106
`define OFF_PC_UPPER_LATCH      9'h10a
`define OFF_INTERRUPT_CONTROL   9'h10b
`define OFF_NVM_DATA_LOW        9'h10c
`define OFF_NVM_ADDRESS_LOW     9'h10d
`define OFF_NVM_DATA_HIGH       9'h10e
// low offsets of the bank-independent core registers
`define LOW_INDIRECT_PORT       7'h00
`define LOW_PC_LOW_BYTE         7'h02
`define LOW_CPU_FLAGS           7'h03
`define LOW_INDIRECT_POINTER    7'h04
`define LOW_PC_UPPER_LATCH      7'h0a
`define LOW_INTERRUPT_CONTROL   7'h0b
// reset values
`define RST_SERIAL_CONTROL_TWO  8'h00
`define RST_TIMER2_PERIOD       8'hff
`define RST_SERIAL_SLAVE_ADDR   8'h00
`define RST_SERIAL_PORT_FLAGS   8'h00
`define RST_CONV_CONFIG_ONE     8'h00
`define RST_PC_LOW_BYTE         8'h00
`define RST_PC_UPPER_LATCH      5'h00
`define RST_CPU_FLAGS_UPPER     5'h03
`define RST_INTERRUPT_UPPER     7'h00
// field layout
`define PC_UPPER_W              5
`define CONV_CONFIG_MASK        8'h8f
`define SERIAL_FLAGS_WR_MASK    8'hc0
`define NVM_DATA_HIGH_MASK      8'h3f
`define CPU_FLAGS_WR_MASK       8'he7

`endif

//--- tb/banked_sfr_map_slice_test.sv
// self-checking bench for the banked register map slice
`timescale 1ns/1ps
`define CHK(a, b, m) begin checks_done++; if ((a) !== (b)) begin miscompares++; $display("mismatch at %0t: %s", $time, m); end end
module banked_sfr_map_slice_test;
  reg        mclk_i = 0, sys_rst_i = 1, wr_en_i = 0, rd_en_i = 0, pc_load_i = 0;
  reg        alu_flags_we_i = 0, int_flags_set_i = 0;
  reg [8:0]  addr_i = 0, a;
  reg [7:0]  wr_data_i = 0, pc_load_low_i = 0, d, p;
  reg [2:0]  alu_flags_i = 0, int_flags_i = 0;
  wire [7:0] rd_data_o, indirect_addr_o, port_b_latch_o, ind_d, tmr, pins, conv;
  wire [7:0] timer2_period_o, serial_control_two_o, cpu_flags_o, interrupt_control_o;
  wire [7:0] ssa, spf, cc1, ndl, nal, ndh;
  wire [12:0] pc_o;
  wire       hit_o, indirect_wr_o, timer0_wr;
  int        miscompares = 0, checks_done = 0, cycles = 0, t0_strobes = 0;
  banked_sfr_map_slice banked_sfr_map_slice_inst (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .addr_i(addr_i),
    .wr_en_i(wr_en_i), .wr_data_i(wr_data_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o), .hit_o(hit_o),
    .pc_load_i(pc_load_i), .pc_load_low_i(pc_load_low_i), .indirect_rd_data_i(ind_d),
    .indirect_wr_o(indirect_wr_o), .indirect_addr_o(indirect_addr_o), .timer0_count_i(tmr),
    .timer0_wr_o(timer0_wr),
    .port_b_pins_i(pins), .port_b_latch_o(port_b_latch_o), .conv_result_low_i(conv),
    .alu_flags_i(alu_flags_i), .alu_flags_we_i(alu_flags_we_i), .power_flags_i(2'b00), .power_flags_we_i(1'b0),
    .int_flags_i(int_flags_i), .int_flags_set_i(int_flags_set_i), .serial_control_two_o(serial_control_two_o),
    .timer2_period_o(timer2_period_o), .serial_slave_address_o(ssa), .serial_port_flags_o(spf),
    .conv_config_one_o(cc1), .cpu_flags_o(cpu_flags_o), .interrupt_control_o(interrupt_control_o),
    .nvm_data_low_o(ndl), .nvm_address_low_o(nal), .nvm_data_high_o(ndh), .pc_o(pc_o));
  core_far_side core_far_side_inst (.ptr_i(indirect_addr_o), .latch_i(port_b_latch_o), .indirect_data_o(ind_d),
    .timer_o(tmr), .pins_o(pins), .conv_o(conv));
  // clock and cycle ceiling
  initial forever #50 mclk_i = ~mclk_i;
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      $display("mismatch at %0t: timeout", $time);
      give_verdict;
    end
  end
  // count timer write strobes; only writes to the timer location may raise one
  always @(posedge mclk_i) begin
    if (timer0_wr === 1'b1) t0_strobes++;
  end
  // one of the fifteen empty locations of the slice
  function automatic [8:0] unmapped(input int k);
    unmapped = k < 2 ? 9'h08f + k : k < 11 ? 9'h093 + k : k == 11 ? 9'h105 : 9'h0fb + k;
  endfunction
  task automatic wr(input [8:0] ad, input [7:0] v);
    @(negedge mclk_i);
    addr_i = ad;
    wr_data_i = v;
    wr_en_i = 1;
    @(negedge mclk_i);
    wr_en_i = 0;
  endtask
  task automatic rd(input [8:0] ad, input [7:0] e);
    @(negedge mclk_i);
    addr_i = ad;
    rd_en_i = 1;
    @(negedge mclk_i);
    rd_en_i = 0;
    `CHK(rd_data_o, e, "read data")
  endtask
  task give_verdict;
    if (miscompares == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // main sequence
  initial begin
    void'($urandom(29968));
    repeat (5) @(posedge mclk_i);
    @(negedge mclk_i);
    sys_rst_i = 0;
    `CHK(timer2_period_o, 8'hff, "period reset")
    `CHK({cpu_flags_o[7:3], pc_o}, 18'h06000, "flags or pc reset")
    `CHK({serial_control_two_o, interrupt_control_o}, 16'h0000, "serial or int reset")
    rd(9'h093, 8'h00);
    // core updates seen through other banks
    alu_flags_i = 3'h5;
    alu_flags_we_i = 1;
    int_flags_i = 3'h6;
    int_flags_set_i = 1;
    @(negedge mclk_i);
    alu_flags_we_i = 0;
    int_flags_set_i = 0;
    rd(9'h183, 8'h1d);
    rd(9'h08b, 8'h06);
    // corners: pointer known before unmapped writes, write masks, shared status, counter low write
    wr(9'h004, 8'h3c);
    wr(9'h094, 8'hff);
    wr(9'h09f, 8'hff);
    wr(9'h10e, 8'hff);
    `CHK({spf, cc1, ndh}, 24'hc08f3f, "write masks")
    rd(9'h094, 8'hc0);
    rd(9'h09f, 8'h8f);
    wr(9'h083, 8'hff);
    rd(9'h103, 8'hff);
    wr(9'h00a, 8'h13);
    wr(9'h182, 8'h5a);
    `CHK(pc_o, 13'h135a, "counter low write")
    rd(9'h102, 8'h5a);
    repeat (40) begin
      a = 9'h091 + 9'($urandom % 3);
      d = $urandom;
      wr(a, d);
      rd(a, d);
      `CHK(a == 9'h091 ? serial_control_two_o : a == 9'h092 ? timer2_period_o : ssa, d, "register output")
      wr(unmapped($urandom % 15), ~d);
      rd(unmapped($urandom % 15), 8'h00);
      rd(a, d);
      p = $urandom;
      wr({2'($urandom), 7'h04}, p);
      rd({2'($urandom), 7'h04}, p);
      rd({2'($urandom), 7'h00}, p ^ 8'h96);
      rd(9'h101, p + 8'h11);
      wr(9'h101, p);
      wr(9'h09e, d);
      rd(9'h09e, {p[3:0], p[7:4]});
      wr(9'h106, d);
      rd(9'h106, ~d);
      wr(9'h10c, d);
      wr(9'h10d, p);
      `CHK({ndl, nal, ndh}, {d, p, 8'h3f}, "nvm registers")
      rd(9'h10d, p);
      d = $urandom & 8'h1f;
      wr({2'($urandom), 7'h0a}, d);
      pc_load_i = 1;
      pc_load_low_i = p;
      @(negedge mclk_i);
      pc_load_i = 0;
      `CHK(pc_o, {d[4:0], p}, "counter load")
      rd(9'h10a, d);
    end
    `CHK(t0_strobes, 40, "timer write strobes")
    // second reset in mid-run: listed values return, the pointer keeps its contents
    sys_rst_i = 1;
    repeat (2) @(negedge mclk_i);
    sys_rst_i = 0;
    `CHK({timer2_period_o, cpu_flags_o[7:3], pc_o, spf, cc1}, {8'hff, 5'h03, 13'h0000, 16'h0000}, "mid-run reset")
    rd(9'h18a, 8'h00);
    rd(9'h104, p);
    give_verdict;
  end
endmodule // banked_sfr_map_slice_test

//--- tb/core_far_side.sv
// far-side core model: memory behind the indirect port and peripheral read values
`timescale 1ns/1ps
module core_far_side (
  input  wire [7:0] ptr_i,
  input  wire [7:0] latch_i,
  output wire [7:0] indirect_data_o,
  output wire [7:0] timer_o,
  output wire [7:0] pins_o,
  output wire [7:0] conv_o
);
  // every memory cell differs so a wrong pointer shows at once
  assign indirect_data_o = ptr_i ^ 8'h96;
  assign timer_o         = ptr_i + 8'h11;
  // pins follow the output latch, inverted through the board
  assign pins_o          = ~latch_i;
  assign conv_o          = {ptr_i[3:0], ptr_i[7:4]};
endmodule // core_far_side

//--- tb/sfr_map_checker_assertions.sv
// concurrent checks on the ports of the register map slice
`timescale 1ns/1ps
module sfr_map_checker (
  input wire       mclk_i, sys_rst_i, wr_en_i, rd_en_i, hit_o, pc_load_i, indirect_wr_o, timer0_wr_o,
  input wire [8:0] addr_i,
  input wire [7:0] wr_data_i, rd_data_o, pc_load_low_i, indirect_addr_o, timer2_period_o,
  input wire [7:0] serial_control_two_o, cpu_flags_o,
  input wire [12:0] pc_o
);
  default clocking @(posedge mclk_i); endclocking
  // latch write followed by a counter load
  sequence s_latch_wr;
    wr_en_i && addr_i[6:0] == 7'h0a;
  endsequence
  sequence s_pc_load;
    pc_load_i;
  endsequence
  a_unmapped_reads_zero: assert property (disable iff (sys_rst_i)
    rd_en_i && !hit_o |=> rd_data_o == 8'h00) else $error("unmapped read not zero");
  a_latch_upper_clear: assert property (disable iff (sys_rst_i)
    rd_en_i && addr_i[6:0] == 7'h0a |=> rd_data_o[7:5] == 3'b000) else $error("latch upper bits set");
  a_pc_from_latch: assert property (disable iff (sys_rst_i)
    s_latch_wr ##1 s_pc_load |=> pc_o == {$past(wr_data_i[4:0], 2), $past(pc_load_low_i)})
    else $error("counter not loaded from latch");
  a_mirror_hit: assert property (disable iff (sys_rst_i)
    addr_i[6:0] inside {7'h00, 7'h02, 7'h03, 7'h04, 7'h0a, 7'h0b} |-> hit_o) else $error("core reg not decoded");
  a_mirror_pointer: assert property (disable iff (sys_rst_i)
    wr_en_i && addr_i[6:0] == 7'h04 |=> indirect_addr_o == $past(wr_data_i)) else $error("pointer write lost");
  a_indirect_strobe: assert property (disable iff (sys_rst_i)
    indirect_wr_o == (wr_en_i && addr_i[6:0] == 7'h00)) else $error("indirect strobe wrong");
  a_reset_values: assert property (
    sys_rst_i |=> timer2_period_o == 8'hff && serial_control_two_o == 8'h00 && pc_o == 13'h0000
    && cpu_flags_o[7:3] == 5'h03) else $error("reset value wrong");
  a_unmapped_write_kept: assert property (disable iff (sys_rst_i)
    wr_en_i && !hit_o && !pc_load_i |=> $stable(timer2_period_o) && $stable(indirect_addr_o) && $stable(pc_o))
    else $error("unmapped write changed state");
  a_dropped_no_strobe: assert property (disable iff (sys_rst_i)
    wr_en_i && !hit_o |-> !timer0_wr_o && !indirect_wr_o) else $error("unmapped write raised a strobe");
endmodule // sfr_map_checker

bind banked_sfr_map_slice sfr_map_checker sfr_map_checker_inst (.mclk_i, .sys_rst_i, .wr_en_i, .rd_en_i, .hit_o,
  .pc_load_i, .indirect_wr_o, .addr_i, .wr_data_i, .rd_data_o, .pc_load_low_i, .indirect_addr_o,
  .timer2_period_o, .serial_control_two_o, .cpu_flags_o, .pc_o, .timer0_wr_o);
